/* File: core/swd_pkg.sv */
// shared constants, types and command decode for the single wire debug link
// assumes both ends run on one 50 MHz clock (20 ns period)
package swd_pkg;
  // device timing, cycles after the perceived start of a bit; DEAD_WAIT counts cycles of a waiting bus access
  localparam logic [3:0] RX_SAMPLE     = 4'h9;
  localparam logic [3:0] TX_ONE_PULSE  = 4'h7;
  localparam logic [3:0] TX_ZERO_LOW   = 4'hd;
  localparam logic [3:0] TX_ZERO_PULSE = 4'he;
  localparam logic [3:0] PHASE_LAST    = 4'hf;
  localparam logic [8:0] TIMEOUT_CYCLES = 9'h100;
  localparam logic [8:0] TIMEOUT_LAST   = TIMEOUT_CYCLES - 9'h001;
  localparam logic [7:0] DEAD_WAIT      = 8'h80;
  localparam logic [7:0] DEAD_WAIT_LAST = DEAD_WAIT - 8'h01;
  // host timing, cycles after the host falling edge
  localparam logic [7:0] HOST_TX_BIT     = 8'h10;
  localparam logic [7:0] HOST_RX_BIT     = 8'h12;
  localparam logic [7:0] HOST_ONE_LOW    = 8'h04;
  localparam logic [7:0] HOST_ZERO_LOW   = 8'h0d;
  localparam logic [7:0] HOST_RX_LOW     = 8'h03;
  localparam logic [7:0] HOST_SAMPLE     = 8'h0a;
  localparam logic [7:0] SYNC_LAT        = 8'h02;
  localparam logic [7:0] HOST_SAMPLE_CYC = HOST_SAMPLE + SYNC_LAT;
  localparam logic [7:0] GAP_CYCLES      = 8'h96;
  // frame lengths in bits
  localparam logic [5:0] LEN_OPC      = 6'h08;
  localparam logic [5:0] LEN_OPC_WORD = 6'h18;
  localparam logic [5:0] LEN_FULL     = 6'h28;
  localparam logic [5:0] LEN_WORD     = 6'h10;
  localparam logic [4:0] LAST_OPC_BIT  = 5'h07;
  localparam logic [4:0] LAST_WORD_BIT = 5'h0f;
  // opcodes and their field layout
  localparam logic [7:0] OPC_BACKGROUND = 8'h90;
  localparam logic [7:0] HW_GROUP_MASK  = 8'hf3;
  localparam logic [7:0] HW_READ_GROUP  = 8'he0;
  localparam logic [7:0] HW_WRITE_GROUP = 8'hc0;
  localparam logic [3:0] FW_READ_NIB    = 4'h6;
  localparam logic [3:0] FW_WRITE_NIB   = 4'h4;
  localparam int         MAP_BIT  = 2;
  localparam int         WORD_BIT = 3;
  // debug map
  localparam logic [15:0] REG_BASE    = 16'hff00;
  localparam logic [15:0] REG_LAST    = 16'hff06;
  localparam logic [15:0] ROM_BASE    = 16'hff20;
  localparam logic [15:0] STATUS_ADDR = 16'hff01;
  localparam int          STATUS_EN_BIT = 7;

  typedef struct packed {
    logic hw;
    logic addr;
    logic wdata;
    logic rdata;
  } swd_fmt_s;

  typedef enum logic [2:0] {D_OPC, D_ADDR, D_WDATA, D_FWDATA, D_MEM, D_FWRD, D_TX} swd_dev_state_e;
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_GAP, H_RECV} swd_host_state_e;

  function automatic swd_fmt_s cmdFormat(input logic [7:0] opc);
    swd_fmt_s f;
    f = '0;
    if ((opc & HW_GROUP_MASK) == HW_READ_GROUP) begin
      f = '{hw: 1'b1, addr: 1'b1, wdata: 1'b0, rdata: 1'b1};
    end else if ((opc & HW_GROUP_MASK) == HW_WRITE_GROUP) begin
      f = '{hw: 1'b1, addr: 1'b1, wdata: 1'b1, rdata: 1'b0};
    end else if (opc == OPC_BACKGROUND) begin
      f.hw = 1'b1;
    end else begin
      f.rdata = (opc[7:4] == FW_READ_NIB);
      f.wdata = (opc[7:4] == FW_WRITE_NIB);
    end
    return f;
  endfunction
endpackage

/* File: core/swd_link_if.sv */
// the single debug wire between host and device
// pseudo-open-drain: pulled high unless a party drives it low
`timescale 1ns/1ps
interface swd_link_if;
  logic hostOut;
  logic hostOe;
  logic devOut;
  logic devOe;
  logic line;

  // a low drive wins; released or driven high reads high
  assign line = ~((hostOe & ~hostOut) | (devOe & ~devOut));

  modport device (input line, output devOut, output devOe);
  modport host   (input line, output hostOut, output hostOe);
endinterface

/* File: core/swd_edge_sync.sv */
// two-flop synchroniser for the debug wire with a falling edge pulse
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module swd_edge_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  output logic      levelSync,
  output logic      fallPulse
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else begin
      sync1_reg <= pinIn;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign levelSync = sync2_reg;
  assign fallPulse = prev_reg & ~sync2_reg;
endmodule

/* File: core/swd_device.sv */
// device end of the single wire debug link: bit engine, command decoder,
// debug enable/active state, debug map decode and cycle-stealing bus access
// assumes the cpu side answers memReq with memAck and reports dead cycles
`timescale 1ns/1ps
module swd_device (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  swd_link_if.device        link,
  input  wire logic         specialSingleChip,
  input  wire logic         instrBoundary,
  input  wire logic         tagHit,
  input  wire logic         swBreak,
  input  wire logic         fwExit,
  input  wire logic [15:0]  cpuAddr,
  input  wire logic         cpuDead,
  output logic              cpuStall,
  output logic              memReq,
  output logic              memWe,
  output logic              memInMap,
  output logic              memByte,
  output logic [15:0]       memAddr,
  output logic [15:0]       memWdata,
  input  wire logic         memAck,
  input  wire logic [15:0]  memRdata,
  output logic              fwCmdValid,
  output logic [7:0]        fwCmd,
  output logic [15:0]       fwWdata,
  input  wire logic         fwRdValid,
  input  wire logic [15:0]  fwRdData,
  output logic              dbgActive,
  output logic              fwEnabled,
  output logic              dbgRegSel,
  output logic              dbgRomSel,
  output logic              periphSuspend
);
  swd_pkg::swd_dev_state_e state_reg;
  swd_pkg::swd_fmt_s       fmt;
  swd_pkg::swd_fmt_s       newFmt;
  logic [3:0]  phase_reg, phase_next;
  logic [8:0]  idle_reg, idle_next;
  logic [4:0]  bitCnt_reg;
  logic [15:0] sh_reg, rxWord, tx_reg, addr_reg, wd_reg;
  logic [7:0]  opc_reg, wait_reg, statusByte;
  logic        lineSync, hostFall, run_reg, run_next, timeout, timeoutClr;
  logic        rxState, rxSample, txBitEnd, lastBit, rxLast, opcDone;
  logic        txBit, inTx, lowNext, highNext, txOwn_reg, txOwn_next, devOe_reg, devOut_reg;
  logic        enable_reg, active_reg, software_break_instruction_reg, strapPend_reg, activate, setBgnd;
  logic        statusHit, statusWr, memWait, memDone, steal_reg, fwCmdValid_reg, fwFire;

  // host edge is asynchronous, so it goes through two flops first
  swd_edge_sync uSync (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pinIn     (link.line),
    .levelSync (lineSync),
    .fallPulse (hostFall)
  );

  // bit phase restarts on every host falling edge
  assign phase_next = hostFall ? 4'h1 : (run_reg ? phase_reg + 4'h1 : phase_reg);
  assign run_next   = hostFall | (run_reg & (phase_reg != swd_pkg::PHASE_LAST));
  assign idle_next  = hostFall ? 9'h000 :
                      ((idle_reg == swd_pkg::TIMEOUT_CYCLES) ? idle_reg : idle_reg + 9'h001);
  assign timeout    = ~hostFall & (idle_reg == swd_pkg::TIMEOUT_LAST);
  // an outstanding bus access is never abandoned halfway
  assign timeoutClr = timeout & (state_reg != swd_pkg::D_MEM);

  assign fmt      = swd_pkg::cmdFormat(opc_reg);
  assign rxState  = (state_reg == swd_pkg::D_OPC) | (state_reg == swd_pkg::D_ADDR) |
                    (state_reg == swd_pkg::D_WDATA) | (state_reg == swd_pkg::D_FWDATA);
  assign rxSample = run_reg & (phase_reg == swd_pkg::RX_SAMPLE) & rxState;
  assign txBitEnd = run_reg & (phase_reg == swd_pkg::PHASE_LAST) & (state_reg == swd_pkg::D_TX) & txOwn_reg;
  assign lastBit  = (state_reg == swd_pkg::D_OPC) ? (bitCnt_reg == swd_pkg::LAST_OPC_BIT) :
                                                    (bitCnt_reg == swd_pkg::LAST_WORD_BIT);
  assign rxLast   = rxSample & lastBit;
  assign rxWord   = {sh_reg[14:0], lineSync};
  assign opcDone  = rxLast & (state_reg == swd_pkg::D_OPC);
  assign newFmt   = swd_pkg::cmdFormat(rxWord[7:0]);

  // pin driver; host bits leave it released
  assign txBit    = tx_reg[15];
  // an answer loaded while a host bit still runs waits for the next host edge
  assign txOwn_next = (state_reg == swd_pkg::D_TX) & (hostFall | (txOwn_reg & run_next));
  assign inTx     = txOwn_next;
  assign lowNext  = inTx & ~txBit & (phase_next <= swd_pkg::TX_ZERO_LOW);
  assign highNext = inTx & ((~txBit & (phase_next == swd_pkg::TX_ZERO_PULSE)) |
                            (txBit & (phase_next == swd_pkg::TX_ONE_PULSE)));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_reg  <= 4'h0;
      run_reg    <= 1'b0;
      idle_reg   <= swd_pkg::TIMEOUT_CYCLES;
      devOe_reg  <= 1'b0;
      devOut_reg <= 1'b0;
      txOwn_reg  <= 1'b0;
    end else begin
      txOwn_reg  <= txOwn_next;
      phase_reg  <= phase_next;
      run_reg    <= run_next;
      idle_reg   <= idle_next;
      devOe_reg  <= lowNext | highNext;
      devOut_reg <= highNext;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst | timeoutClr) begin
      bitCnt_reg <= 5'h00;
      sh_reg     <= 16'h0000;
    end else if (rxSample | txBitEnd) begin
      bitCnt_reg <= lastBit ? 5'h00 : bitCnt_reg + 5'h01;
      sh_reg     <= rxLast ? 16'h0000 : rxWord;
    end
  end

  // command sequencing
  assign statusHit = fmt.hw & opc_reg[swd_pkg::MAP_BIT] & (addr_reg == swd_pkg::STATUS_ADDR);
  assign statusByte = {enable_reg, active_reg, 6'h00};
  assign memWait   = (state_reg == swd_pkg::D_MEM) & ~statusHit;
  assign memReq    = memWait & (cpuDead | steal_reg);
  assign memDone   = memReq & memAck;
  assign cpuStall  = memWait & steal_reg;

  always_ff @(posedge clk) begin
    if (sys_rst | timeoutClr) begin
      state_reg <= swd_pkg::D_OPC;
    end else begin
      case (state_reg)
        swd_pkg::D_OPC: begin
          if (opcDone) begin
            opc_reg <= rxWord[7:0];
            if (newFmt.hw) begin
              state_reg <= newFmt.addr ? swd_pkg::D_ADDR : swd_pkg::D_OPC;
            end else if (active_reg & newFmt.wdata) begin
              state_reg <= swd_pkg::D_FWDATA;
            end else if (active_reg & newFmt.rdata) begin
              state_reg <= swd_pkg::D_FWRD;
            end
          end
        end
        swd_pkg::D_ADDR: begin
          if (rxLast) begin
            addr_reg  <= rxWord;
            state_reg <= fmt.wdata ? swd_pkg::D_WDATA : swd_pkg::D_MEM;
          end
        end
        swd_pkg::D_WDATA: begin
          if (rxLast) begin
            wd_reg    <= rxWord;
            state_reg <= swd_pkg::D_MEM;
          end
        end
        swd_pkg::D_FWDATA: begin
          if (rxLast) begin
            wd_reg    <= rxWord;
            state_reg <= swd_pkg::D_OPC;
          end
        end
        swd_pkg::D_MEM: begin
          if (statusHit) begin
            tx_reg    <= {8'h00, statusByte};
            state_reg <= fmt.rdata ? swd_pkg::D_TX : swd_pkg::D_OPC;
          end else if (memDone) begin
            tx_reg    <= memRdata;
            state_reg <= fmt.rdata ? swd_pkg::D_TX : swd_pkg::D_OPC;
          end
        end
        swd_pkg::D_FWRD: begin
          if (fwRdValid) begin
            tx_reg    <= fwRdData;
            state_reg <= swd_pkg::D_TX;
          end
        end
        swd_pkg::D_TX: begin
          if (txBitEnd) begin
            tx_reg <= {tx_reg[14:0], 1'b0};
            if (lastBit) begin
              state_reg <= swd_pkg::D_OPC;
            end
          end
        end
        default: begin
          state_reg <= swd_pkg::D_OPC;
        end
      endcase
    end
  end

  // dead-cycle wait, then steal
  always_ff @(posedge clk) begin
    if (sys_rst | ~memWait | memDone) begin
      wait_reg  <= 8'h00;
      steal_reg <= 1'b0;
    end else begin
      wait_reg  <= wait_reg + 8'h01;
      steal_reg <= steal_reg | (wait_reg == swd_pkg::DEAD_WAIT_LAST);
    end
  end

  // firmware hand-off
  assign fwFire = (opcDone & ~newFmt.hw & active_reg & ~newFmt.wdata) |
                  (rxLast & (state_reg == swd_pkg::D_FWDATA));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fwCmdValid_reg <= 1'b0;
    end else begin
      fwCmdValid_reg <= fwFire;
    end
  end

  // enable and active state; activation wins over a same-cycle exit
  assign statusWr = (state_reg == swd_pkg::D_MEM) & statusHit & fmt.wdata;
  assign setBgnd  = opcDone & (rxWord[7:0] == swd_pkg::OPC_BACKGROUND) & enable_reg;
  assign activate = (software_break_instruction_reg & instrBoundary) | (enable_reg & (tagHit | swBreak));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_reg    <= 1'b0;
      active_reg    <= 1'b0;
      software_break_instruction_reg      <= 1'b0;
      strapPend_reg <= 1'b1;
    end else if (strapPend_reg) begin
      // mode strap caught on the first edge after reset release
      enable_reg    <= specialSingleChip;
      active_reg    <= specialSingleChip;
      strapPend_reg <= 1'b0;
    end else begin
      enable_reg <= statusWr ? wd_reg[swd_pkg::STATUS_EN_BIT] : enable_reg;
      active_reg <= activate | (active_reg & ~fwExit);
      software_break_instruction_reg   <= setBgnd | (software_break_instruction_reg & ~activate);
    end
  end

  assign link.devOe  = devOe_reg;
  assign link.devOut = devOut_reg;
  assign memWe       = fmt.wdata;
  assign memInMap    = opc_reg[swd_pkg::MAP_BIT];
  assign memByte     = ~opc_reg[swd_pkg::WORD_BIT];
  assign memAddr     = addr_reg;
  assign memWdata    = wd_reg;
  assign fwCmdValid  = fwCmdValid_reg;
  assign fwCmd       = opc_reg;
  assign fwWdata     = wd_reg;
  assign dbgActive   = active_reg;
  assign fwEnabled   = enable_reg;
  assign dbgRegSel   = active_reg & (cpuAddr >= swd_pkg::REG_BASE) & (cpuAddr <= swd_pkg::REG_LAST);
  assign dbgRomSel   = active_reg & (cpuAddr >= swd_pkg::ROM_BASE);
  assign periphSuspend = active_reg;
endmodule

/* File: core/swd_host.sv */
// host end of the single wire debug link: sends a command frame,
// waits the command gap and clocks the answer word back
// assumes one command at a time from the user side
`timescale 1ns/1ps
module swd_host (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  swd_link_if.host          link,
  input  wire logic         cmdValid,
  output logic              cmdReady,
  input  wire logic [7:0]   cmdOpcode,
  input  wire logic [15:0]  cmdAddr,
  input  wire logic [15:0]  cmdWdata,
  output logic              rspValid,
  output logic [15:0]       rspData
);
  swd_pkg::swd_host_state_e state_reg;
  swd_pkg::swd_fmt_s        cf;
  logic        lineSync;
  logic [7:0]  cnt_reg;
  logic [5:0]  left_reg;
  logic [39:0] tx_reg;
  logic [15:0] rx_reg;
  logic        rdata_reg;
  logic        rspValid_reg;
  logic [7:0]  lowLen;
  logic        bitEndTx;
  logic        bitEndRx;
  logic        gapEnd;

  swd_edge_sync uSync (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pinIn     (link.line),
    .levelSync (lineSync),
    .fallPulse ()
  );

  assign cf       = swd_pkg::cmdFormat(cmdOpcode);
  assign cmdReady = (state_reg == swd_pkg::H_IDLE);
  assign lowLen   = tx_reg[39] ? swd_pkg::HOST_ONE_LOW : swd_pkg::HOST_ZERO_LOW;
  assign bitEndTx = (cnt_reg == swd_pkg::HOST_TX_BIT - 8'h01);
  assign bitEndRx = (cnt_reg == swd_pkg::HOST_RX_BIT - 8'h01);
  assign gapEnd   = (cnt_reg == swd_pkg::GAP_CYCLES - 8'h01);

  // every bit opens low; own bits are driven high actively, answer bits released
  assign link.hostOe  = (state_reg == swd_pkg::H_SEND) |
                        ((state_reg == swd_pkg::H_RECV) & (cnt_reg < swd_pkg::HOST_RX_LOW));
  assign link.hostOut = (state_reg == swd_pkg::H_SEND) & (cnt_reg >= lowLen);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg    <= swd_pkg::H_IDLE;
      cnt_reg      <= 8'h00;
      left_reg     <= 6'h00;
      tx_reg       <= 40'h0;
      rx_reg       <= 16'h0000;
      rdata_reg    <= 1'b0;
      rspValid_reg <= 1'b0;
    end else begin
      rspValid_reg <= 1'b0;
      case (state_reg)
        swd_pkg::H_IDLE: begin
          cnt_reg <= 8'h00;
          if (cmdValid) begin
            rdata_reg <= cf.rdata;
            state_reg <= swd_pkg::H_SEND;
            if (cf.addr & cf.wdata) begin
              tx_reg   <= {cmdOpcode, cmdAddr, cmdWdata};
              left_reg <= swd_pkg::LEN_FULL;
            end else if (cf.addr | cf.wdata) begin
              tx_reg   <= {cmdOpcode, (cf.addr ? cmdAddr : cmdWdata), 16'h0000};
              left_reg <= swd_pkg::LEN_OPC_WORD;
            end else begin
              tx_reg   <= {cmdOpcode, 32'h0};
              left_reg <= swd_pkg::LEN_OPC;
            end
          end
        end
        swd_pkg::H_SEND: begin
          cnt_reg <= bitEndTx ? 8'h00 : cnt_reg + 8'h01;
          if (bitEndTx) begin
            tx_reg   <= {tx_reg[38:0], 1'b0};
            left_reg <= left_reg - 6'h01;
            if (left_reg == 6'h01) begin
              state_reg <= swd_pkg::H_GAP;
            end
          end
        end
        swd_pkg::H_GAP: begin
          cnt_reg <= gapEnd ? 8'h00 : cnt_reg + 8'h01;
          if (gapEnd) begin
            left_reg  <= swd_pkg::LEN_WORD;
            state_reg <= rdata_reg ? swd_pkg::H_RECV : swd_pkg::H_IDLE;
          end
        end
        swd_pkg::H_RECV: begin
          cnt_reg <= bitEndRx ? 8'h00 : cnt_reg + 8'h01;
          if (cnt_reg == swd_pkg::HOST_SAMPLE_CYC) begin
            rx_reg <= {rx_reg[14:0], lineSync};
          end
          if (bitEndRx) begin
            left_reg <= left_reg - 6'h01;
            if (left_reg == 6'h01) begin
              rspValid_reg <= 1'b1;
              state_reg    <= swd_pkg::H_IDLE;
            end
          end
        end
        default: begin
          state_reg <= swd_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign rspValid = rspValid_reg;
  assign rspData  = rx_reg;
endmodule

/* File: tb/swd_link_checker.sv */
// wire-level checks on both drivers of the debug link
// assumes one clock and the resolved wire from the link interface
`timescale 1ns/1ps
module swd_link_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hostOut,
  input wire logic hostOe,
  input wire logic devOut,
  input wire logic devOe,
  input wire logic line
);
  logic       lineQ;
  logic [7:0] sinceFall;
  wire        lowDrv  = devOe & ~devOut;
  wire        hiDrv   = devOe & devOut;
  wire        fallNow = lineQ & ~line;

  // saturates so a long idle never wraps into a legal bit period
  always_ff @(posedge clk) begin
    lineQ     <= sys_rst | line;
    sinceFall <= sys_rst ? 8'hff : (fallNow ? 8'h00 : sinceFall + {7'h00, sinceFall != 8'hff});
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence zeroBit;
    lowDrv [*8] ##1 lowDrv [*5] ##1 hiDrv;
  endsequence

  a_bit_period: assert property ($fell(line) |-> sinceFall == 8'h0f || sinceFall >= 8'h11)
    else $error("host edges closer than a bit period");
  a_host_low: assert property ($fell(line) |-> !line [*2])
    else $error("host low drive shorter than two cycles");
  a_dev_quiet: assert property (hostOe |-> !devOe)
    else $error("device drives while host drives");
  a_zero_start: assert property ($rose(lowDrv) |-> sinceFall inside {[1:4]})
    else $error("zero bit starts off the perceived edge");
  a_zero_len: assert property ($rose(lowDrv) |-> zeroBit)
    else $error("zero bit not low for 13 cycles then pulse");
  a_one_pulse: assert property (hiDrv && !$past(devOe) |-> sinceFall inside {[7:10]})
    else $error("one pulse not at cycle seven");
  a_pulse_brief: assert property (hiDrv |=> !devOe)
    else $error("high drive longer than one cycle");
  a_dev_window: assert property (devOe |-> sinceFall <= 8'h11)
    else $error("device drives outside its bit time");
endmodule

/* File: tb/tb.sv */
// self-checking bench: host and device ends joined over the debug wire
// assumes the cpu side (memory, dead cycles, firmware replies) is modelled here
`timescale 1ns/1ps
module tb;
  logic        clk, sys_rst, cmdValid, cmdReady, rspValid, instrBoundary, swBreak, fwExit, cpuDead;
  logic        cpuStall, memReq, memWe, memInMap, memByte, memAck, fwCmdValid, fwRdValid;
  logic        dbgActive, fwEnabled, dbgRegSel, dbgRomSel, periphSuspend;
  logic        tagHit, strap, deadOff;
  logic [7:0]  cmdOpcode, fwCmd;
  logic [15:0] cmdAddr, cmdWdata, rspData, cpuAddr, memAddr, memWdata, memRdata, fwWdata, fwRdData, fwVal, a, d;
  logic [15:0] mem [logic [15:0]];
  logic [15:0] expq [$];
  logic [15:0] mapAddr [5] = '{16'hff00, 16'hff06, 16'hff07, 16'hff20, 16'hfeff};
  logic [1:0]  mapSel [5]  = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h0};
  int          seed = 63566;
  int          errors = 0;
  int          compares = 0;

  swd_link_if link ();
  swd_device u_swd_device (.clk(clk), .sys_rst(sys_rst), .link(link), .specialSingleChip(strap),
    .instrBoundary(instrBoundary), .tagHit(tagHit), .swBreak(swBreak), .fwExit(fwExit), .cpuAddr(cpuAddr),
    .cpuDead(cpuDead), .cpuStall(cpuStall), .memReq(memReq), .memWe(memWe), .memInMap(memInMap),
    .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
    .fwCmdValid(fwCmdValid), .fwCmd(fwCmd), .fwWdata(fwWdata), .fwRdValid(fwRdValid), .fwRdData(fwRdData),
    .dbgActive(dbgActive), .fwEnabled(fwEnabled), .dbgRegSel(dbgRegSel), .dbgRomSel(dbgRomSel),
    .periphSuspend(periphSuspend));
  swd_host u_swd_host (.clk(clk), .sys_rst(sys_rst), .link(link), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .rspValid(rspValid), .rspData(rspData));
  swd_link_checker u_swd_link_checker (.clk(clk), .sys_rst(sys_rst), .hostOut(link.hostOut),
    .hostOe(link.hostOe), .devOut(link.devOut), .devOe(link.devOe), .line(link.line));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // cpu side: random dead cycles and ack delays exercise dead-cycle use; deadOff removes dead cycles to force stealing
  always @(posedge clk) begin
    cpuDead       <= ~deadOff & 1'($random(seed));
    instrBoundary <= 1'($random(seed));
    memAck        <= memReq & ~memAck & 1'($random(seed));
    memRdata      <= mem.exists(memAddr) ? mem[memAddr] : 16'h0000;
    if (memReq & memAck & memWe) mem[memAddr] = memWdata;
    if (memReq & memAck) chk16("mem flags", 16'h0000, {14'h0000, memInMap, memByte});
    if (memReq & memAck & deadOff) chk16("cpuStall", 16'h0001, {15'h0000, cpuStall});
    fwRdValid     <= fwCmdValid;
    fwRdData      <= fwVal;
  end

  always @(posedge clk) if (rspValid === 1'b1) chk16("rspData", expq.pop_front(), rspData);

  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // one whole command; returns once the host end is idle again
  task automatic send(input logic [7:0] op, input logic [15:0] ad, dt, input logic rd, input logic [15:0] ex);
    if (rd) expq.push_back(ex);
    cmdValid  <= 1'b1;
    cmdOpcode <= op;
    cmdAddr   <= ad;
    cmdWdata  <= dt;
    @(posedge clk);
    cmdValid <= 1'b0;
    repeat (2) @(posedge clk);
    while (cmdReady !== 1'b1) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask

  task automatic pulse(input logic brk);
    if (brk) swBreak <= 1'b1;
    else fwExit <= 1'b1;
    @(posedge clk);
    swBreak <= 1'b0;
    fwExit  <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    {cmdValid, swBreak, fwExit, cpuDead, instrBoundary, memAck, fwRdValid, tagHit, strap, deadOff} = '0;
    {cmdOpcode, cmdAddr, cmdWdata, cpuAddr, memRdata, fwRdData, fwVal} = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    send(8'he4, 16'hff01, 16'h0000, 1'b1, 16'h0000);
    send(8'hc4, 16'hff01, 16'h0080, 1'b0, 16'h0000);
    send(8'he4, 16'hff01, 16'h0000, 1'b1, 16'h0080);
    for (int i = 0; i < 3; i++) begin
      // no dead cycles in the last pass, so the access must steal
      deadOff <= (i == 2);
      a = 16'($random(seed)) & 16'h7ffe;
      d = 16'($random(seed));
      send(8'hc8, a, d, 1'b0, 16'h0000);
      send(8'he8, a, 16'h0000, 1'b1, d);
    end
    deadOff <= 1'b0;
    send(8'h90, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    send(8'he4, 16'hff01, 16'h0000, 1'b1, 16'h00c0);
    chk16("periphSuspend", 16'h0001, {15'h0000, periphSuspend});
    foreach (mapAddr[i]) begin
      cpuAddr <= mapAddr[i];
      @(posedge clk);
      #1 chk16("map select", {14'h0000, mapSel[i]}, {14'h0000, dbgRegSel, dbgRomSel});
    end
    fwVal <= 16'($random(seed));
    @(posedge clk);
    send(8'h65, 16'h0000, 16'h0000, 1'b1, fwVal);
    send(8'h45, 16'h0000, fwVal, 1'b0, 16'h0000);
    chk16("fwWdata", fwVal, fwWdata);
    chk16("fwCmd", 16'h0045, {8'h00, fwCmd});
    pulse(1'b0);
    cpuAddr <= 16'hff06;
    @(posedge clk);
    #1 chk16("inactive map", 16'h0000, {14'h0000, dbgRegSel, dbgRomSel});
    @(posedge clk);
    pulse(1'b1);
    chk16("break activates", 16'h0001, {15'h0000, dbgActive});
    pulse(1'b0);
    send(8'h65, 16'h0000, 16'h0000, 1'b1, 16'hffff);
    send(8'hc4, 16'hff01, 16'h0000, 1'b0, 16'h0000);
    pulse(1'b1);
    chk16("break unenabled", 16'h0000, {15'h0000, dbgActive});
    // second reset with the special single-chip strap set
    strap   <= 1'b1;
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk16("strap", 16'h0003, {14'h0000, fwEnabled, dbgActive});
    pulse(1'b0);
    tagHit <= 1'b1;
    @(posedge clk);
    tagHit <= 1'b0;
    repeat (3) @(posedge clk);
    chk16("tag activates", 16'h0001, {15'h0000, dbgActive});
    summarize();
  end

  // about fifteen commands of at most roughly 830 cycles each fit well inside this
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule
